// ===== hdl/xpt_host.sv
// Avalon-MM controlled host driving the crosspoint control pins
`timescale 1ns/1ps
`default_nettype none
`include "xpt_host_cfg.svh"

// How it works
// - Top address bit picks connection or current bank
// - Low address bits output index; data input index
// - Write plus commit passes straight; readback gates
// - Write and commit strobes held 10 ns minimum
// - Host releases data lines during readback
module xpt_host #(
  parameter int STROBE_CYC = `XPT_STROBE_CYC,
  parameter int READ_CYC   = `XPT_READ_CYC + `XPT_SYNC_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output var  logic [31:0] avs_readdata_o,
  output var  logic        avs_waitrequest_o,
  output var  logic [6:0]  xp_addr_o,
  input  wire logic [5:0]  xp_data_i,
  output var  logic [5:0]  xp_data_o,
  output var  logic        xp_data_oe_o,
  output var  logic        xp_cs_n_o,
  output var  logic        xp_we_n_o,
  output var  logic        output_query_n_o,
  output var  logic        commit_strobe_n_o,
  output var  logic        xp_reset_n_o
);

  xpt_host_pkg::host_state_type s_r;
  xpt_host_pkg::host_state_type s_nxt;

  logic       busy;
  logic       cmd_sel;
  logic       accept_wr;
  logic       bad_idx;
  logic [2:0] new_op;
  logic [3:0] strobe_last;
  logic [3:0] read_last;

  assign strobe_last = 4'(STROBE_CYC - 1);
  assign read_last   = 4'(READ_CYC - 1);
  assign busy        = (s_r.st != xpt_host_pkg::ST_IDLE);
  assign cmd_sel     = (avs_address_i == `XPT_REG_CMD);
  assign accept_wr   = avs_write_i & ~s_r.wait_n;
  assign new_op      = avs_writedata_i[2:0];
  // Indices past the last output, broadcast excepted, are refused
  assign bad_idx     = (s_r.addr[5:0] > `XPT_LAST_OUT) &&
                       (s_r.addr[5:0] != `XPT_BCAST_IDX);

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.wait_n = 1'b1;
    s_nxt.sync1  = xp_data_i;
    s_nxt.sync2  = s_r.sync1;
    s_nxt.rst_n  = 1'b1;

    // Bus slave: one ready cycle per access; commands stall while busy
    if ((avs_read_i | avs_write_i) & s_r.wait_n &
        ~(avs_write_i & cmd_sel & busy)) begin
      s_nxt.wait_n = 1'b0;
      s_nxt.rd_bus = 32'h0000_0000;
      case (avs_address_i)
        `XPT_REG_ADDR:   s_nxt.rd_bus[6:0] = s_r.addr;
        `XPT_REG_DATA:   s_nxt.rd_bus[5:0] = s_r.wdata;
        `XPT_REG_CMD:    s_nxt.rd_bus[2:0] = s_r.op;
        `XPT_REG_STATUS: begin
          s_nxt.rd_bus[`XPT_ST_BUSY]               = busy;
          s_nxt.rd_bus[`XPT_ST_DONE]               = s_r.done;
          s_nxt.rd_bus[`XPT_ST_ERR]                = s_r.err;
          s_nxt.rd_bus[`XPT_ST_RD_LSB+5:`XPT_ST_RD_LSB] = s_r.rdata;
        end
        default:         s_nxt.rd_bus = 32'h0000_0000;
      endcase
    end

    if (accept_wr) begin
      case (avs_address_i)
        `XPT_REG_ADDR: s_nxt.addr  = avs_writedata_i[6:0];
        `XPT_REG_DATA: s_nxt.wdata = avs_writedata_i[5:0];
        default:       s_nxt.addr  = s_nxt.addr;
      endcase
    end

    case (s_r.st)
      xpt_host_pkg::ST_IDLE: begin
        if (accept_wr & cmd_sel) begin
          s_nxt.op   = new_op;
          s_nxt.done = 1'b0;
          s_nxt.err  = 1'b0;
          s_nxt.pin_addr = s_r.addr;
          if (s_r.addr[`XPT_BANK_BIT])
            s_nxt.pin_data = s_r.wdata & `XPT_CUR_MASK;
          else
            s_nxt.pin_data = s_r.wdata;
          case (new_op)
            `XPT_OP_WRITE, `XPT_OP_TRANS, `XPT_OP_READ: begin
              if (bad_idx) begin
                s_nxt.err  = 1'b1;
                s_nxt.done = 1'b1;
              end else begin
                s_nxt.st     = xpt_host_pkg::ST_SETUP;
                s_nxt.cs_n   = 1'b0;
                // Readback never drives the shared lines
                s_nxt.pin_oe = (new_op != `XPT_OP_READ);
              end
            end
            `XPT_OP_COMMIT: begin
              s_nxt.st   = xpt_host_pkg::ST_SETUP;
              s_nxt.cs_n = 1'b0;
            end
            `XPT_OP_RESET: begin
              s_nxt.st    = xpt_host_pkg::ST_ACTIVE;
              s_nxt.rst_n = 1'b0;
              s_nxt.cnt   = strobe_last;
            end
            default: s_nxt.err = 1'b1;
          endcase
        end
      end
      xpt_host_pkg::ST_SETUP: begin
        // Address, data and select settle a cycle before any strobe
        s_nxt.st = xpt_host_pkg::ST_ACTIVE;
        case (s_r.op)
          `XPT_OP_WRITE: begin
            s_nxt.we_n = 1'b0;
            s_nxt.cnt  = strobe_last;
          end
          `XPT_OP_COMMIT: begin
            s_nxt.commit_n = 1'b0;
            s_nxt.cnt      = strobe_last;
          end
          `XPT_OP_TRANS: begin
            // Readback stays high: it gates the pass-through
            s_nxt.we_n     = 1'b0;
            s_nxt.commit_n = 1'b0;
            s_nxt.cnt      = strobe_last;
          end
          default: begin
            s_nxt.query_n = 1'b0;
            s_nxt.cnt     = read_last;
          end
        endcase
      end
      xpt_host_pkg::ST_ACTIVE: begin
        s_nxt.rst_n = s_r.rst_n;
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.st       = xpt_host_pkg::ST_HOLD;
          s_nxt.rst_n    = 1'b1;
          s_nxt.we_n     = 1'b1;
          s_nxt.commit_n = 1'b1;
          s_nxt.query_n  = 1'b1;
          if (s_r.op == `XPT_OP_READ)
            s_nxt.rdata = s_r.sync2;
        end
      end
      xpt_host_pkg::ST_HOLD: begin
        // Select and data release one cycle after the strobe rises
        s_nxt.st     = xpt_host_pkg::ST_IDLE;
        s_nxt.cs_n   = 1'b1;
        s_nxt.pin_oe = 1'b0;
        s_nxt.done   = 1'b1;
      end
      default: s_nxt.st = xpt_host_pkg::ST_IDLE;
    endcase
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r          <= '0;
      s_r.st       <= xpt_host_pkg::ST_IDLE;
      s_r.wait_n   <= 1'b1;
      s_r.cs_n     <= 1'b1;
      s_r.we_n     <= 1'b1;
      s_r.query_n  <= 1'b1;
      s_r.commit_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o    = s_r.rd_bus;
  assign avs_waitrequest_o = s_r.wait_n;
  assign xp_addr_o         = s_r.pin_addr;
  assign xp_data_o         = s_r.pin_data;
  assign xp_data_oe_o      = s_r.pin_oe;
  assign xp_cs_n_o         = s_r.cs_n;
  assign xp_we_n_o         = s_r.we_n;
  assign output_query_n_o  = s_r.query_n;
  assign commit_strobe_n_o = s_r.commit_n;
  assign xp_reset_n_o      = s_r.rst_n;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  logic [3:0] low_cnt_r;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i)
      low_cnt_r <= 4'h0;
    else if (!s_r.we_n || !s_r.commit_n)
      low_cnt_r <= low_cnt_r + 4'h1;
    else
      low_cnt_r <= 4'h0;
  end

  property p_release;
    @(posedge mclk_i) disable iff (!resetn_i)
      !s_r.query_n |-> !s_r.pin_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("Data lines driven during readback");

  property p_width;
    @(posedge mclk_i) disable iff (!resetn_i)
      ($rose(s_r.we_n) || $rose(s_r.commit_n)) |->
        (low_cnt_r >= 4'(STROBE_CYC));
  endproperty
  a_width: assert property (p_width)
    else $error("Strobe shorter than minimum width");

  property p_gate;
    @(posedge mclk_i) disable iff (!resetn_i)
      (!s_r.we_n && !s_r.commit_n) |-> (s_r.query_n && s_r.pin_oe);
  endproperty
  a_gate: assert property (p_gate)
    else $error("Pass-through without readback gate high");

  property p_bank;
    @(posedge mclk_i) disable iff (!resetn_i)
      (!s_r.we_n && s_r.pin_addr[`XPT_BANK_BIT]) |->
        (s_r.pin_data[5:4] == 2'b00);
  endproperty
  a_bank: assert property (p_bank)
    else $error("Current word carries upper bits");

  property p_refuse;
    @(posedge mclk_i) disable iff (!resetn_i)
      (accept_wr && cmd_sel && !busy && bad_idx &&
       (new_op == `XPT_OP_WRITE)) |=> (s_r.cs_n && s_r.err) [*3];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("Out-of-range output index reached pins");

  property p_addr;
    @(posedge mclk_i) disable iff (!resetn_i)
      (!s_r.we_n || !s_r.query_n) |->
        ($stable(s_r.pin_addr) && !s_r.cs_n);
  endproperty
  a_addr: assert property (p_addr)
    else $error("Address or select moved under a strobe");

  property p_wait;
    @(posedge mclk_i) disable iff (!resetn_i)
      !s_r.wait_n |=> s_r.wait_n;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Waitrequest low longer than one cycle");

  property p_reset;
    @(posedge mclk_i) disable iff (!resetn_i)
      (accept_wr && cmd_sel && !busy && new_op == `XPT_OP_RESET) |=>
        !s_r.rst_n ##(STROBE_CYC) s_r.rst_n;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Device reset pulse has wrong length");

  property p_index;
    @(posedge mclk_i) disable iff (!resetn_i)
      $fell(s_r.we_n) |-> (s_r.pin_addr == s_r.addr);
  endproperty
  a_index: assert property (p_index)
    else $error("Written index differs from address register");

endmodule : xpt_host

`default_nettype wire

// ===== hdl/xpt_host_cfg.svh
// Offsets, field positions, command codes and timing counts of the host
`ifndef XPT_HOST_CFG_SVH
`define XPT_HOST_CFG_SVH

// ---------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ---------------------------------------------------------------------
`define XPT_REG_ADDR     4'h0
`define XPT_REG_DATA     4'h4
`define XPT_REG_CMD      4'h8
`define XPT_REG_STATUS   4'hC

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define XPT_BANK_BIT     6
`define XPT_ST_BUSY      0
`define XPT_ST_DONE      1
`define XPT_ST_ERR       2
`define XPT_ST_RD_LSB    8

// ---------------------------------------------------------------------
// Command codes written to the command register
// ---------------------------------------------------------------------
`define XPT_OP_WRITE     3'h1
`define XPT_OP_COMMIT    3'h2
`define XPT_OP_READ      3'h3
`define XPT_OP_TRANS     3'h4
`define XPT_OP_RESET     3'h5

// ---------------------------------------------------------------------
// Output index limits and bank encodings
// ---------------------------------------------------------------------
`define XPT_LAST_OUT     6'h21
`define XPT_BCAST_IDX    6'h3F
`define XPT_CUR_MASK     6'h0F

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define XPT_CLK_MHZ      100
`define XPT_STROBE_NS    10
`define XPT_READ_NS      30
`define XPT_SYNC_CYC     3
`define XPT_STROBE_CYC   (((`XPT_STROBE_NS * `XPT_CLK_MHZ) + 999) / 1000)
`define XPT_READ_CYC     (((`XPT_READ_NS * `XPT_CLK_MHZ) + 999) / 1000)

`endif

// ===== hdl/xpt_host_pkg.sv
// Types of the crosspoint configuration host
`default_nettype none
package xpt_host_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACTIVE,
    ST_HOLD
  } state_type;

  typedef struct packed {
    state_type   st;
    logic [3:0]  cnt;
    logic [2:0]  op;
    logic [6:0]  addr;
    logic [5:0]  wdata;
    logic [5:0]  rdata;
    logic        done;
    logic        err;
    logic        wait_n;
    logic [31:0] rd_bus;
    logic        cs_n;
    logic        we_n;
    logic        query_n;
    logic        commit_n;
    logic        rst_n;
    logic [6:0]  pin_addr;
    logic [5:0]  pin_data;
    logic        pin_oe;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
  } host_state_type;

endpackage : xpt_host_pkg

`default_nettype wire

// ===== tb/xpt_dev_model.sv
// Behavioural crosspoint control port answering the host pins
`timescale 1ns/1ps
`default_nettype none
module xpt_dev_model (
  input  wire logic       mclk_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [5:0] data_i,
  input  wire logic       cs_n_i,
  input  wire logic       we_n_i,
  input  wire logic       query_n_i,
  input  wire logic       commit_n_i,
  input  wire logic       reset_n_i,
  output var  logic [5:0] data_o,
  output var  logic       data_oe_o
);
  logic [5:0] rank1_r [128];
  logic [5:0] rank2_r [128];
  logic [5:0] word;

  // Latch i is written now (broadcast on index 63, none on 34..62)
  function automatic logic sel(input int i);
    logic ok;
    ok = addr_i[5:0] <= 6'h21 || addr_i[5:0] == 6'h3F;
    return ok && !we_n_i && query_n_i && i[6] == addr_i[6] &&
           (i[5:0] == addr_i[5:0] || addr_i[5:0] == 6'h3F);
  endfunction : sel

  assign word      = addr_i[6] ? (data_i & 6'h0F) : data_i;
  assign data_oe_o = reset_n_i && !cs_n_i && !query_n_i;
  assign data_o    = rank2_r[addr_i];

  // Levels sampled mid-cycle, away from the host's launch edge
  always @(negedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 128; i++) begin
        rank1_r[i] <= i[6] ? 6'h07 : 6'h3F;
        rank2_r[i] <= i[6] ? 6'h07 : 6'h3F;
      end
    end else if (!cs_n_i) begin
      for (int i = 0; i < 128; i++) begin
        if (sel(i)) rank1_r[i] <= word;
        if (!commit_n_i) rank2_r[i] <= sel(i) ? word : rank1_r[i];
      end
    end
  end
endmodule : xpt_dev_model
`default_nettype wire

// ===== tb/xpt_host_tb_top.sv
// Self-checking bench for the crosspoint configuration host
`timescale 1ns/1ps
`default_nettype none
`include "xpt_host_cfg.svh"
module xpt_host_tb_top;
  logic        mclk_i, resetn_i, avs_read_i, avs_write_i, dev_oe;
  logic        clash = 1'b0;
  logic [5:0]  last_r = 6'h00;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, st;
  logic        avs_waitrequest_o, xp_data_oe_o, xp_cs_n_o, xp_we_n_o;
  logic        output_query_n_o, commit_strobe_n_o, xp_reset_n_o;
  logic [6:0]  xp_addr_o;
  logic [5:0]  xp_data_o, xp_data_i, dev_data;
  int          num_errors = 0, check_count = 0, cyc = 0;

  // Undriven lines show the inverse of their last level
  assign xp_data_i = xp_data_oe_o ? xp_data_o : dev_oe ? dev_data : ~last_r;

  xpt_host xpt_host_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .xp_addr_o(xp_addr_o), .xp_data_i(xp_data_i), .xp_data_o(xp_data_o),
    .xp_data_oe_o(xp_data_oe_o), .xp_cs_n_o(xp_cs_n_o),
    .xp_we_n_o(xp_we_n_o), .output_query_n_o(output_query_n_o),
    .commit_strobe_n_o(commit_strobe_n_o), .xp_reset_n_o(xp_reset_n_o));

  xpt_dev_model xpt_dev_model_i (.mclk_i(mclk_i), .addr_i(xp_addr_o),
    .data_i(xp_data_i), .cs_n_i(xp_cs_n_o), .we_n_i(xp_we_n_o),
    .query_n_i(output_query_n_o), .commit_n_i(commit_strobe_n_o),
    .reset_n_i(xp_reset_n_o), .data_o(dev_data), .data_oe_o(dev_oe));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    last_r <= xp_data_i;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end

  always @(negedge mclk_i) begin
    if (xp_data_oe_o === 1'b1 && dev_oe === 1'b1) clash <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n == 100) begin
      num_errors++;
      end_of_test;
    end
  endtask : av

  task automatic run_op(input logic [6:0] a, input logic [5:0] d,
                        input logic [2:0] c, output logic [31:0] s);
    int n;
    n = 0;
    av(1'b1, `XPT_REG_ADDR, {25'h0, a}, s);
    av(1'b1, `XPT_REG_DATA, {26'h0, d}, s);
    av(1'b1, `XPT_REG_CMD, {29'h0, c}, s);
    do begin
      av(1'b0, `XPT_REG_STATUS, 32'h0, s);
      n++;
    end while ((s[0] !== 1'b0 || (s[1] !== 1'b1 && s[2] !== 1'b1)) && n < 50);
    // A command that never finishes must not slip through to the verdict
    if (n == 50) begin
      num_errors++;
      end_of_test;
    end
  endtask : run_op

  task automatic rb(input logic [6:0] a, input logic [5:0] exp);
    logic [31:0] s;
    run_op(a, 6'h00, `XPT_OP_READ, s);
    chk({26'h0, s[13:8]}, {26'h0, exp});
  endtask : rb

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rb(7'h05, 6'h3F);
    rb(7'h45, 6'h07);
    $display("test reset defaults done");
    run_op(7'h03, 6'h21, `XPT_OP_WRITE, st);
    chk(st & 32'h0000_0007, 32'h0000_0002);
    rb(7'h03, 6'h3F);
    run_op(7'h61, 6'h3A, `XPT_OP_WRITE, st);
    av(1'b0, `XPT_REG_ADDR, 32'h0, st);
    chk(st, 32'h0000_0061);
    av(1'b0, `XPT_REG_DATA, 32'h0, st);
    chk(st, 32'h0000_003A);
    av(1'b0, `XPT_REG_CMD, 32'h0, st);
    chk(st, 32'h0000_0001);
    run_op(7'h00, 6'h00, `XPT_OP_COMMIT, st);
    rb(7'h03, 6'h21);
    rb(7'h61, 6'h0A);
    rb(7'h21, 6'h3F);
    chk({31'h0, xp_cs_n_o}, 32'h1);
    // Second command while a readback runs must stall, then be taken
    av(1'b1, `XPT_REG_CMD, {29'h0, `XPT_OP_READ}, st);
    av(1'b1, `XPT_REG_CMD, {29'h0, `XPT_OP_COMMIT}, st);
    av(1'b0, `XPT_REG_CMD, 32'h0, st);
    chk(st, 32'h0000_0002);
    $display("test two ranks done");
    run_op(7'h3F, 6'h05, `XPT_OP_WRITE, st);
    run_op(7'h00, 6'h00, `XPT_OP_COMMIT, st);
    rb(7'h00, 6'h05);
    rb(7'h21, 6'h05);
    rb(7'h61, 6'h0A);
    run_op(7'h07, 6'h3F, `XPT_OP_TRANS, st);
    rb(7'h07, 6'h3F);
    $display("test broadcast and transparent done");
    run_op(7'h28, 6'h01, `XPT_OP_WRITE, st);
    chk({31'h0, st[2]}, 32'h1);
    run_op(7'h00, 6'h00, 3'h7, st);
    chk({31'h0, st[2]}, 32'h1);
    av(1'b0, 4'h2, 32'h0, st);
    chk(st, 32'h0);
    run_op(7'h00, 6'h00, `XPT_OP_RESET, st);
    rb(7'h03, 6'h3F);
    rb(7'h61, 6'h07);
    chk({31'h0, clash}, 32'h0);
    $display("test refusals and reset done");
    end_of_test;
  end
endmodule : xpt_host_tb_top
`default_nettype wire
